// File: src/icap_map.svh
/*
  Register offsets, field positions, reset values and mode codes for the
  capture block. Assumes byte addresses on an APB bus with 32-bit data.
*/
`ifndef ICAP_MAP_SVH
`define ICAP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define TIMER_B_CONTROL_OFS 8'h00
`define TIMER_B_COUNT_OFS 8'h04
`define CAP_CONFIG_BASE 8'h20
`define CAP_BUFFER_BASE 8'h40
`define CAP_BLOCK_MASK 8'hE0

// ----------------------------------------------------------------------
// Timer b control fields
// ----------------------------------------------------------------------
`define TB_RUN_BIT 15
`define TB_IDLE_BIT 13
`define TB_GATE_BIT 6
`define TB_PRESC_LSB 4
`define TB_CLKSRC_BIT 1
`define TIMER_B_CONTROL_RESET 16'h0000

// ----------------------------------------------------------------------
// Capture config fields and mode codes
// ----------------------------------------------------------------------
`define CAP_TBSEL_BIT 7
`define CAP_CPI_LSB 5
`define CAP_OVF_BIT 4
`define CAP_BNE_BIT 3
`define CAP_MODE_LSB 0
`define CAP_MODE_OFF 3'h0
`define CAP_MODE_EVERY 3'h1
`define CAP_MODE_FALL 3'h2
`define CAP_MODE_RISE 3'h3
`define CAP_MODE_RISE4 3'h4
`define CAP_MODE_RISE16 3'h5
`define CAP_MODE_IRQONLY 3'h7
`define FIFO_DEPTH 3'h4

`endif

// File: src/icap_pkg.sv
/*
  Types shared by the capture block and its bench.
  Assumes the constants of icap_map.svh.
*/
package icap_pkg;
  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;

  // Timer b control fields as stored
  typedef struct packed {
    logic run;
    logic idle_halt;
    logic gate_accumulate;
    logic [1:0] prescale_select;
    logic clock_source_select;
  } timer_ctrl_type;

  // Capture channel setup as stored
  typedef struct packed {
    logic timebase_select;
    logic [1:0] captures_per_interrupt;
    logic [2:0] mode;
  } cap_cfg_type;
endpackage

// File: src/input_capture_with_timebase.sv
/*
  Timer b time base with its control register and eight input capture
  channels, each with a four-word buffer, behind an APB slave.
  Assumes pins are asynchronous, timer a's count comes from its own block
  on this clock, and the core signals idle, sleep and 32-bit pairing.
*/
`timescale 1ns/1ps
`default_nettype none
`include "icap_map.svh"

module input_capture_with_timebase (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire icap_pkg::apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and core status
  input wire logic [7:0] capture_input_pin,
  input wire logic ext_timer_clock_pin,
  input wire logic [15:0] timer_a_count,
  input wire logic pair_32bit_mode,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  // Events
  output logic [7:0] capture_irq,
  output logic wake_request
);
  import icap_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  timer_ctrl_type tctrl_reg;
  cap_cfg_type cfg_reg [8];
  logic [15:0] count_reg;
  logic [7:0] presc_reg;
  logic half_reg;
  logic [8:0] s1_reg, s2_reg, s3_reg, lvl_reg;
  logic [8:0] rise, fall;
  logic [15:0] fifo_mem [8][4];
  logic [1:0] wp_reg [8];
  logic [1:0] rp_reg [8];
  logic [2:0] cnt_reg [8];
  logic [7:0] ovf_reg;
  logic [3:0] pre_reg [8];
  logic [1:0] evc_reg [8];
  logic [7:0] cap_ev, ext_ev, pop;
  logic [31:0] prdata_reg;
  logic pop_ok_reg;
  logic run_eff, src_tick, tick;
  logic acc, setup, wr, mapped;
  logic [2:0] ch;

  // Last prescaler count for each divide setting
  function automatic logic [7:0] presc_last(input logic [1:0] sel);
    case (sel)
      2'h1: presc_last = 8'h07;
      2'h2: presc_last = 8'h3F;
      2'h3: presc_last = 8'hFF;
      default: presc_last = 8'h00;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  // Three stages; a level change counts once stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      s1_reg <= 9'h000;
      s2_reg <= 9'h000;
      s3_reg <= 9'h000;
      lvl_reg <= 9'h000;
    end else begin
      s1_reg <= {ext_timer_clock_pin, capture_input_pin};
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= (s2_reg & s3_reg) | (lvl_reg & (s2_reg | s3_reg));
    end
  end
  assign rise = s2_reg & s3_reg & ~lvl_reg;
  assign fall = ~s2_reg & ~s3_reg & lvl_reg;

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  assign setup = apb_req.psel & ~apb_req.penable;
  assign acc = apb_req.psel & apb_req.penable;
  assign wr = acc & apb_req.pwrite;
  assign ch = apb_req.paddr[4:2];
  assign mapped = (apb_req.paddr[1:0] == 2'h0) &&
                  (apb_req.paddr == `TIMER_B_CONTROL_OFS || apb_req.paddr == `TIMER_B_COUNT_OFS ||
                   (apb_req.paddr & `CAP_BLOCK_MASK) == `CAP_CONFIG_BASE ||
                   (apb_req.paddr & `CAP_BLOCK_MASK) == `CAP_BUFFER_BASE);
  // Zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_reg;

  // ----------------------------------------------------------------------
  // Timer b
  // ----------------------------------------------------------------------
  // pairing voids: timer b's own controls lose effect when paired
  // idle halt: core idle stops the timer only if halt bit set
  assign run_eff = tctrl_reg.run & ~pair_32bit_mode & ~(cpu_idle & tctrl_reg.idle_halt);
  // clock source: pin rising edge, or every other cycle
  // gate accumulate: gate pin level only counts on internal clock
  assign src_tick = tctrl_reg.clock_source_select ? rise[8] :
                    (half_reg & (~tctrl_reg.gate_accumulate | lvl_reg[8]));
  assign tick = run_eff & src_tick;

  // Internal clock is half the module clock
  always_ff @(posedge clock) begin
    if (!rst_n) half_reg <= 1'b0;
    else half_reg <= ~half_reg;
  end

  // Control register, written by software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tctrl_reg <= timer_ctrl_type'(6'h00);
    end else if (wr && mapped && apb_req.paddr == `TIMER_B_CONTROL_OFS) begin
      tctrl_reg.run <= apb_req.pwdata[`TB_RUN_BIT];
      tctrl_reg.idle_halt <= apb_req.pwdata[`TB_IDLE_BIT];
      tctrl_reg.gate_accumulate <= apb_req.pwdata[`TB_GATE_BIT];
      tctrl_reg.prescale_select <= apb_req.pwdata[`TB_PRESC_LSB +: 2];
      tctrl_reg.clock_source_select <= apb_req.pwdata[`TB_CLKSRC_BIT];
    end
  end

  // prescale divide: count only at the last prescaler step
  // count step: one per prescaled tick; software write wins
  // run control: stopped timer holds count and prescaler
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count_reg <= 16'h0000;
      presc_reg <= 8'h00;
    end else if (wr && mapped && apb_req.paddr == `TIMER_B_COUNT_OFS) begin
      count_reg <= apb_req.pwdata[15:0];
      presc_reg <= 8'h00;
    end else if (tick) begin
      if (presc_reg >= presc_last(tctrl_reg.prescale_select)) begin
        presc_reg <= 8'h00;
        count_reg <= count_reg + 16'h0001;
      end else begin
        presc_reg <= presc_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Capture event selection
  // ----------------------------------------------------------------------
  // eight channels: each decodes its own pin edges by mode
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      cap_ev[i] = 1'b0;
      ext_ev[i] = 1'b0;
      case (cfg_reg[i].mode)
        `CAP_MODE_EVERY: cap_ev[i] = rise[i] | fall[i];
        `CAP_MODE_FALL: cap_ev[i] = fall[i];
        `CAP_MODE_RISE: cap_ev[i] = rise[i];
        `CAP_MODE_RISE4: cap_ev[i] = rise[i] & (pre_reg[i][1:0] == 2'h3);
        `CAP_MODE_RISE16: cap_ev[i] = rise[i] & (pre_reg[i] == 4'hF);
        // external interrupt: no capture, interrupt only
        `CAP_MODE_IRQONLY: ext_ev[i] = rise[i];
        default: cap_ev[i] = 1'b0;
      endcase
      pop[i] = acc & ~apb_req.pwrite & pop_ok_reg & (ch == 3'(i)) &
               ((apb_req.paddr & `CAP_BLOCK_MASK) == `CAP_BUFFER_BASE);
    end
  end

  // Channel setup, plus edge prescaler that restarts on any write to its own channel's setup
  always_ff @(posedge clock) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_n) begin
        cfg_reg[i] <= cap_cfg_type'(6'h00);
        pre_reg[i] <= 4'h0;
      end else if (wr && mapped && (apb_req.paddr & `CAP_BLOCK_MASK) == `CAP_CONFIG_BASE && ch == 3'(i)) begin
        cfg_reg[i].timebase_select <= apb_req.pwdata[`CAP_TBSEL_BIT];
        cfg_reg[i].captures_per_interrupt <= apb_req.pwdata[`CAP_CPI_LSB +: 2];
        cfg_reg[i].mode <= apb_req.pwdata[`CAP_MODE_LSB +: 3];
        pre_reg[i] <= 4'h0;
      end else if (rise[i]) begin
        pre_reg[i] <= pre_reg[i] + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Capture buffers
  // ----------------------------------------------------------------------
  // four words: full buffer drops the capture and flags overflow
  // capture store, timer pick, set selects timer a
  // oldest first: read pointer walks behind the write pointer
  // Mode off empties the buffer and clears overflow; no capture or pop happens while off
  always_ff @(posedge clock) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_n) begin
        wp_reg[i] <= 2'h0;
        rp_reg[i] <= 2'h0;
        cnt_reg[i] <= 3'h0;
        ovf_reg[i] <= 1'b0;
      end else begin
        if (cfg_reg[i].mode == `CAP_MODE_OFF) begin
          rp_reg[i] <= wp_reg[i];
          cnt_reg[i] <= 3'h0;
          ovf_reg[i] <= 1'b0;
        end else begin
          if (pop[i]) rp_reg[i] <= rp_reg[i] + 2'h1;
          if (cap_ev[i] && cnt_reg[i] == `FIFO_DEPTH) ovf_reg[i] <= 1'b1;
          if (cap_ev[i] && cnt_reg[i] != `FIFO_DEPTH) begin
            fifo_mem[i][wp_reg[i]] <= cfg_reg[i].timebase_select ? timer_a_count : count_reg;
            wp_reg[i] <= wp_reg[i] + 2'h1;
            if (!pop[i]) cnt_reg[i] <= cnt_reg[i] + 3'h1;
          end else if (pop[i]) begin
            cnt_reg[i] <= cnt_reg[i] - 3'h1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt and wake pulses
  // ----------------------------------------------------------------------
  // capture interrupt, after 1..4, code plus one
  always_ff @(posedge clock) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_n) begin
        evc_reg[i] <= 2'h0;
        capture_irq[i] <= 1'b0;
      end else begin
        capture_irq[i] <= ext_ev[i] | (cap_ev[i] && evc_reg[i] >= cfg_reg[i].captures_per_interrupt);
        if (cfg_reg[i].mode == `CAP_MODE_OFF) evc_reg[i] <= 2'h0;
        else if (cap_ev[i])
          evc_reg[i] <= (evc_reg[i] >= cfg_reg[i].captures_per_interrupt) ? 2'h0 : evc_reg[i] + 2'h1;
      end
    end
  end

  // wake: any channel event while the core sleeps or idles
  always_ff @(posedge clock) begin
    if (!rst_n) wake_request <= 1'b0;
    else wake_request <= (cpu_sleep | cpu_idle) & |(cap_ev | ext_ev);
  end

  // ----------------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------------
  // Loaded in setup so data stands through the access cycle; a read of
  // an empty buffer returns zero and removes nothing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prdata_reg <= 32'h0000_0000;
      pop_ok_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= 32'h0000_0000;
      pop_ok_reg <= 1'b0;
      if (apb_req.paddr == `TIMER_B_CONTROL_OFS)
        prdata_reg <= {16'h0000, tctrl_reg.run, 1'b0, tctrl_reg.idle_halt, 6'h00, tctrl_reg.gate_accumulate,
                       tctrl_reg.prescale_select, 2'h0, tctrl_reg.clock_source_select, 1'b0};
      else if (apb_req.paddr == `TIMER_B_COUNT_OFS)
        prdata_reg <= {16'h0000, count_reg};
      else if (mapped && (apb_req.paddr & `CAP_BLOCK_MASK) == `CAP_CONFIG_BASE)
        prdata_reg <= {24'h000000, cfg_reg[ch].timebase_select, cfg_reg[ch].captures_per_interrupt,
                       ovf_reg[ch], cnt_reg[ch] != 3'h0, cfg_reg[ch].mode};
      else if (mapped && (apb_req.paddr & `CAP_BLOCK_MASK) == `CAP_BUFFER_BASE && cnt_reg[ch] != 3'h0) begin
        prdata_reg <= {16'h0000, fifo_mem[ch][rp_reg[ch]]};
        pop_ok_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  timer_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    (!tctrl_reg.run && !wr) |=> count_reg == $past(count_reg)) else $error("timer moved while stopped");
  idle_halt_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cpu_idle && tctrl_reg.idle_halt) |-> !tick) else $error("timer ticked in idle with halt set");
  pair_void_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pair_32bit_mode && !wr) |=> $stable(count_reg)) else $error("timer b moved while paired");
  count_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tick && tctrl_reg.prescale_select == 2'h0 && !wr) |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("count did not step on tick");
  ext_gate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (run_eff && tctrl_reg.clock_source_select) |-> tick == rise[8]) else $error("gate not ignored");
  fall_cap_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cfg_reg[0].mode == `CAP_MODE_FALL && fall[0]) |-> cap_ev[0]) else $error("fall not captured");
  every_irq_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cap_ev[0] && cfg_reg[0].captures_per_interrupt == 2'h0) |=> capture_irq[0]) else $error("irq missing");
  fifo_fill_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cap_ev[0] && cnt_reg[0] < 3'h4 && !pop[0]) |=> cnt_reg[0] == $past(cnt_reg[0]) + 3'h1)
    else $error("capture not stored");
  oldest_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    (setup && apb_req.paddr == `CAP_BUFFER_BASE && cnt_reg[0] != 3'h0)
    |=> prdata[15:0] == $past(fifo_mem[0][rp_reg[0]])) else $error("read not oldest");
endmodule // input_capture_with_timebase

`default_nettype wire

// File: test/pulse_source.sv
/*
  Behavioural signal source for the eight capture pins and the timer
  clock pin. Assumes a caller that asks for levels and pulse bursts.
*/
`timescale 1ns/1ps
`default_nettype none

module pulse_source (
  // Clock
  input wire logic clock,
  // Pins toward the capture block
  output logic [7:0] capture_input_pin,
  output logic ext_timer_clock_pin
);
  // Source is always driving, so no released level is ever seen
  initial begin
    capture_input_pin = 8'h00;
    ext_timer_clock_pin = 1'b0;
  end

  // Move the masked pins to a level, then hold it for the synchronisers
  task automatic set_pins(input logic [7:0] mask, input logic lvl, input int hold);
    @(posedge clock);
    capture_input_pin <= lvl ? (capture_input_pin | mask) : (capture_input_pin & ~mask);
    repeat (hold) @(posedge clock);
  endtask

  // Burst of square pulses; the clock pin stands low between bursts
  task automatic ext_pulses(input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      @(posedge clock);
      ext_timer_clock_pin <= 1'b1;
      repeat (hold) @(posedge clock);
      ext_timer_clock_pin <= 1'b0;
      repeat (hold) @(posedge clock);
    end
  endtask
endmodule // pulse_source

`default_nettype wire

// File: test/tb_top.sv
/*
  Self-checking bench: register table, timer b counting, capture modes.
  Assumes the pulse_source model drives the pins.
*/
`timescale 1ns/1ps
`default_nettype none
`include "icap_map.svh"

module tb_top;
  import icap_pkg::*;
  // ----------------------------------------------------------------
  // Hookup
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] exp;
    logic err;
  } row_type;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  apb_req_type req = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic ext_pin;
  logic wake_request;
  logic pair = 1'b0;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic [7:0] pins;
  logic [7:0] capture_irq;
  logic [15:0] ta = 16'h0000;
  logic [31:0] rv;
  logic err;
  int bad_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int irq_cnt = 0;
  int wake_cnt = 0;
  int divs [4] = '{1, 8, 64, 256};
  logic [2:0] mcode [3] = '{`CAP_MODE_EVERY, `CAP_MODE_FALL, `CAP_MODE_RISE};
  int mcnt [3] = '{2, 1, 1};
  logic [15:0] mfirst [3] = '{16'h0001, 16'h0002, 16'h0001};
  row_type rows [8] = '{
    '{8'h00, 32'hFFFFFFFF, 32'h0000A072, 1'b0},
    '{8'h00, 32'h00000000, 32'h00000000, 1'b0},
    '{8'h04, 32'h00001234, 32'h00001234, 1'b0},
    '{8'h3C, 32'h000000FF, 32'h000000E7, 1'b0},
    '{8'h3C, 32'h00000000, 32'h00000000, 1'b0},
    '{8'h02, 32'h0000FFFF, 32'h00000000, 1'b1},
    '{8'h80, 32'h00005A5A, 32'h00000000, 1'b1},
    '{8'h3E, 32'h000000FF, 32'h00000000, 1'b1}};

  always #2 clock = ~clock;

  pulse_source src (.clock(clock), .capture_input_pin(pins), .ext_timer_clock_pin(ext_pin));

  input_capture_with_timebase DUT (.clock(clock), .rst_n(rst_n), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .capture_input_pin(pins), .ext_timer_clock_pin(ext_pin),
    .timer_a_count(ta), .pair_32bit_mode(pair), .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep),
    .capture_irq(capture_irq), .wake_request(wake_request));

  // Event counters; the cycle ceiling cuts a hang short
  always @(posedge clock) begin
    cycles++;
    if (capture_irq[0] === 1'b1) irq_cnt++;
    if (wake_request === 1'b1) wake_cnt++;
    if (cycles == 40000) begin
      bad_count++;
      results();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clock);
    req.penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rv = prdata;
    err = pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Run timer b for a while, stop it, then read the count
  task automatic tmr(input logic [31:0] ctrl, input int w, input int n_ext, input int lo, input int hi);
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, ctrl);
    repeat (w) @(posedge clock);
    src.ext_pulses(n_ext, 3);
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(32'(rv >= lo && rv <= hi), 32'h1);
  endtask

  // Timer a shows k while the pins move
  task automatic edge_to(input logic [7:0] m, input logic v, input logic [15:0] k);
    @(posedge clock);
    ta <= k;
    src.set_pins(m, v, 6);
  endtask

  // Pop n words expecting first, first+1, ... then an empty buffer
  task automatic drain(input logic [2:0] ch, input int n, input logic [15:0] first);
    for (int i = 0; i < n; i++) begin
      apb(1'b0, 8'h40 + {3'h0, ch, 2'h0}, 32'h0);
      chk(rv, 32'(first + i));
    end
    apb(1'b0, 8'h20 + {3'h0, ch, 2'h0}, 32'h0);
    chk(32'(rv[3]), 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk(32'({capture_irq, wake_request}), 32'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(rv, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].addr, rows[i].wdata);
      chk(32'(err), 32'(rows[i].err));
      apb(1'b0, rows[i].addr, 32'h0);
      chk(rv, rows[i].exp);
    end
    // run bit and prescale divide of the half clock
    tmr(32'h0000, 40, 0, 0, 0);
    for (int p = 0; p < 4; p++) begin
      tmr(32'(32'h8000 | (p << 4)), 40 * divs[p], 0, 19, 22);
    end
    // idle halt and pairing freeze the count
    cpu_idle <= 1'b1;
    tmr(32'hA000, 40, 0, 0, 0);
    tmr(32'h8000, 40, 0, 19, 22);
    cpu_idle <= 1'b0;
    pair <= 1'b1;
    // paired setup keeps idle halt clear
    tmr(32'h8000, 40, 0, 0, 0);
    pair <= 1'b0;
    // gate held low stops counting; external source ignores gate
    tmr(32'h8040, 40, 0, 0, 0);
    tmr(32'h8040, 0, 10, 10, 20);
    tmr(32'h8042, 0, 10, 10, 10);
    // edge modes store their own edges
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, 8'h20, 32'h80 | 32'(mcode[m]));
      edge_to(8'h01, 1'b1, 16'h0001);
      edge_to(8'h01, 1'b0, 16'h0002);
      drain(3'h0, mcnt[m], mfirst[m]);
      apb(1'b1, 8'h20, 32'h0);
    end
    // prescaled capture on the 4th and 16th rise
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 8'h20, 32'h80 | 32'(m ? `CAP_MODE_RISE16 : `CAP_MODE_RISE4));
      for (int k = 1; k <= (m ? 16 : 4); k++) begin
        edge_to(8'h01, 1'b1, 16'(k));
        edge_to(8'h01, 1'b0, 16'(k));
      end
      drain(3'h0, 1, m ? 16'h0010 : 16'h0004);
      apb(1'b1, 8'h20, 32'h0);
    end
    // four words kept, fifth dropped with overflow
    apb(1'b1, 8'h20, 32'h81);
    for (int k = 1; k <= 5; k++) begin
      edge_to(8'h01, 1'(k % 2), 16'(k));
    end
    apb(1'b0, 8'h20, 32'h0);
    chk(rv & 32'h18, 32'h18);
    drain(3'h0, 4, 16'h0001);
    apb(1'b0, 8'h40, 32'h0);
    chk(rv, 32'h0);
    apb(1'b1, 8'h20, 32'h0);
    edge_to(8'h01, 1'b0, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      apb(1'b1, 8'h20, 32'(32'h83 | (c << 5)));
      irq_cnt = 0;
      for (int k = 0; k < 4; k++) begin
        edge_to(8'h01, 1'b1, 16'h0000);
        edge_to(8'h01, 1'b0, 16'h0000);
      end
      chk(32'(irq_cnt), 32'(4 / (c + 1)));
      apb(1'b1, 8'h20, 32'h0);
    end
    // select clear stores the stopped timer b count
    apb(1'b1, 8'h04, 32'h0055);
    apb(1'b1, 8'h20, 32'(`CAP_MODE_RISE));
    edge_to(8'h01, 1'b1, 16'h1111);
    edge_to(8'h01, 1'b0, 16'h1111);
    drain(3'h0, 1, 16'h0055);
    apb(1'b1, 8'h20, 32'h0);
    // last channel on its own pin
    apb(1'b1, 8'h3C, 32'h83);
    edge_to(8'h80, 1'b1, 16'h0077);
    edge_to(8'h80, 1'b0, 16'h0077);
    drain(3'h7, 1, 16'h0077);
    apb(1'b1, 8'h3C, 32'h0);
    // pin event in sleep: interrupt and wake, nothing stored
    cpu_sleep <= 1'b1;
    apb(1'b1, 8'h20, 32'h87);
    irq_cnt = 0;
    wake_cnt = 0;
    edge_to(8'h01, 1'b1, 16'h0000);
    edge_to(8'h01, 1'b0, 16'h0000);
    chk(32'(irq_cnt), 32'h1);
    chk(32'(wake_cnt > 0), 32'h1);
    drain(3'h0, 0, 16'h0000);
    cpu_sleep <= 1'b0;
    // Second reset in mid-run returns control to zero
    apb(1'b1, 8'h00, 32'hA072);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    chk(rv, 32'h0);
    results();
  end
endmodule // tb_top

`default_nettype wire
